// ===== dv/fbm_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbm_flash_model #(
  parameter [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
  parameter [15:0] DEV_CODE = 16'h5a3c, // Arbitrary value
  parameter real   ACCESS_NS = 150.0    // Access time in ns
) (
  input  wire logic [18:0] i_addr,        // Address pins
  input  wire logic [15:0] i_dq,          // Data from host
  input  wire logic        i_chip_sel_n,  // Chip select
  input  wire logic        i_out_gate_n,  // Output gate
  input  wire logic        i_wr_strobe_n, // Write strobe
  input  wire logic        i_reset_n,     // Reset pin
  input  wire logic        i_reset_hv,    // Reset elevated
  input  wire logic        i_id_hv,       // Id line elevated
  input  wire logic        i_out_gate_hv, // Gate elevated
  output var  logic [15:0] o_dq,          // Data to host
  output var  logic        o_drive        // Device drives data
);
  logic [15:0]  mem [0:255];
  logic [127:0] prot = '0;
  logic [15:0]  val = 16'h0000;
  logic [15:0]  nv;
  logic [18:0]  wa;
  realtime      t_fall, t_rst;
  wire          wr_n = i_chip_sel_n | i_wr_strobe_n;
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
  always @(negedge wr_n) begin
    wa = i_addr;
    t_fall = $realtime;
  end
  // data on earlier rise, glitches dropped
  always @(posedge wr_n) if (i_reset_n && $realtime - t_fall >= 5.0) begin
    if (i_out_gate_hv) prot = wa[6] ? (&prot ? '0 : prot) : prot | (128'h1 << wa[18:12]);
    else if (i_out_gate_n && (!prot[wa[18:12]] || i_reset_hv)) mem[{wa[15:12], wa[3:0]}] = i_dq;
  end
  always @(posedge i_reset_n) t_rst = $realtime;
  assign o_drive = i_reset_n && !i_chip_sel_n && !i_out_gate_n && i_wr_strobe_n;
  assign o_dq = o_drive ? val : ~val;
  // garbage until one access time after a change
  always @(i_addr or i_id_hv or o_drive) begin
    nv = !i_id_hv ? mem[{i_addr[15:12], i_addr[3:0]}] : i_addr[1] ?
      {15'h0000, prot[i_addr[18:12]]} : i_addr[0] ? DEV_CODE : MFR_CODE;
    if ($realtime - t_rst < 50.0) nv = ~nv;
    val = ~val;
    val <= #(ACCESS_NS) nv;
  end
endmodule // fbm_flash_model
`default_nettype wire

// ===== dv/fbm_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fbm_host_assertions #(
  parameter AW = 19,
  parameter DW = 16
) (
  input wire logic          i_clock,       // System clock
  input wire logic          i_sys_rst,     // Async reset
  input wire logic          o_done,        // Done pulse
  input wire logic          o_busy,        // Busy level
  input wire logic [AW-1:0] o_addr,        // Address pins
  input wire logic [DW-1:0] o_dq_out,      // Data drive
  input wire logic          o_dq_oe,       // Data enable
  input wire logic          o_chip_sel_n,  // Chip select
  input wire logic          o_out_gate_n,  // Output gate
  input wire logic          o_wr_strobe_n, // Write strobe
  input wire logic          o_reset_n,     // Device reset
  input wire logic          o_id_hv,       // Id line elevated
  input wire logic          o_out_gate_hv  // Output gate elevated
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_data_latch;
    $rose(o_wr_strobe_n) && o_dq_oe;
  endsequence
  a_write_pins: assert property (!o_wr_strobe_n |-> !o_chip_sel_n && (o_out_gate_n || o_out_gate_hv))
    else $error("strobe low without select or with gate low");
  a_strobe_width: assert property ($fell(o_wr_strobe_n) |=> !o_wr_strobe_n)
    else $error("strobe pulse too short");
  a_data_held: assert property (s_data_latch |-> $stable(o_dq_out) && $stable(o_addr) && !o_chip_sel_n)
    else $error("data or address moved at strobe rise");
  a_no_contention: assert property (o_dq_oe |-> o_out_gate_n)
    else $error("data driven while gate low");
  a_id_lines: assert property (o_id_hv && !o_out_gate_n && !o_chip_sel_n |-> !o_addr[6])
    else $error("id read with unprotect line high");
  a_recovery: assert property ($rose(o_reset_n) |-> o_out_gate_n [*5])
    else $error("read started inside recovery time");
  a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done not a single idle pulse");
  a_select_busy: assert property (!o_chip_sel_n |-> o_busy)
    else $error("chip selected while idle");
endmodule // fbm_host_assertions
bind fbm_host fbm_host_assertions #(.AW(AW), .DW(DW)) u_chk (.i_clock, .i_sys_rst, .o_done,
  .o_busy, .o_addr, .o_dq_out, .o_dq_oe, .o_chip_sel_n, .o_out_gate_n, .o_wr_strobe_n,
  .o_reset_n, .o_id_hv, .o_out_gate_hv);
`default_nettype wire

// ===== dv/fbm_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fbm_host_tb;
  localparam [15:0] MFR = 16'h00a5; // Arbitrary value
  localparam [15:0] DEV = 16'h5a3c; // Arbitrary value
  logic        i_clock = 0, i_sys_rst = 1, i_req = 0, i_dev_reset = 0, i_temp_unprot = 0;
  logic [2:0]  i_op = 3'h0;
  logic [18:0] i_addr = '0, o_addr;
  logic [15:0] i_wdata = '0, o_rdata, o_dq_out, dev_dq;
  logic        o_busy, o_done, o_protected, o_dq_oe, o_chip_sel_n, o_out_gate_n;
  logic        o_wr_strobe_n, o_reset_n, o_reset_hv, o_id_hv, o_out_gate_hv, dev_drv;
  int          fail_count = 0, n_tests = 0;
  wire [15:0]  i_dq_in = o_dq_oe ? o_dq_out : dev_dq;
  fbm_host dut_u (.i_clock, .i_sys_rst, .i_req, .i_op, .i_addr, .i_wdata, .i_dev_reset,
    .i_temp_unprot, .i_dq_in, .o_busy, .o_done, .o_rdata, .o_protected, .o_addr, .o_dq_out,
    .o_dq_oe, .o_chip_sel_n, .o_out_gate_n, .o_wr_strobe_n, .o_reset_n, .o_reset_hv,
    .o_id_hv, .o_out_gate_hv);
  fbm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash_u (.i_addr(o_addr), .i_dq(o_dq_out),
    .i_chip_sel_n(o_chip_sel_n), .i_out_gate_n(o_out_gate_n), .i_wr_strobe_n(o_wr_strobe_n),
    .i_reset_n(o_reset_n), .i_reset_hv(o_reset_hv), .i_id_hv(o_id_hv),
    .i_out_gate_hv(o_out_gate_hv), .o_dq(dev_dq), .o_drive(dev_drv));
  always #5 i_clock = ~i_clock;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic t_op(input logic [2:0] c, input logic [18:0] a, input logic [15:0] d);
    @(posedge i_clock);
    i_req <= 1'b1;
    i_op <= c;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_req <= 1'b0;
    for (int k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_clock);
    chk_flag(o_done, 1'b1);
  endtask
  task automatic t_rw;
    i_dev_reset <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_dev_reset <= 1'b0;
    t_op(3'h0, 19'h03006, 16'h0000);
    chk(o_rdata, 16'hffff);
    t_op(3'h1, 19'h03005, 16'h1234);
    t_op(3'h0, 19'h03005, 16'h0000);
    chk(o_rdata, 16'h1234);
  endtask
  task automatic t_id;
    t_op(3'h2, 19'h00000, 16'h0000);
    chk(o_rdata, MFR);
    t_op(3'h3, 19'h00000, 16'h0000);
    chk(o_rdata, DEV);
  endtask
  task automatic t_prot;
    for (int s = 0; s < 128; s++) t_op(3'h5, 19'(s << 12), 16'h0000);
    t_op(3'h4, 19'h01000, 16'h0000);
    chk_flag(o_protected, 1'b1);
    t_op(3'h1, 19'h01003, 16'h5555);
    t_op(3'h0, 19'h01003, 16'h0000);
    chk(o_rdata, 16'hffff);
    @(posedge i_clock);
    i_temp_unprot <= 1'b1;
    t_op(3'h1, 19'h01003, 16'h5555);
    @(posedge i_clock);
    i_temp_unprot <= 1'b0;
    t_op(3'h0, 19'h01003, 16'h0000);
    chk(o_rdata, 16'h5555);
    // Protection is back once the elevated level is gone
    t_op(3'h1, 19'h01003, 16'h0a0a);
    t_op(3'h0, 19'h01003, 16'h0000);
    chk(o_rdata, 16'h5555);
    t_op(3'h6, 19'h00000, 16'h0000);
    t_op(3'h4, 19'h01000, 16'h0000);
    chk_flag(o_protected, 1'b0);
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_rw();
    t_id();
    t_prot();
    give_verdict();
  end
  // About 140 operations of under 40 cycles each, with margin
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule // fbm_host_tb
`default_nettype wire

// ===== rtl/fbm_host.v
// Summary of operation
// - Identifier read: id line elevated, code-select low gives maker, high device.
// - Write needs chip select, write strobe low, output gate high.
// - Unprotect clears all sectors; protect all sectors first.
// - Protection query: read offset 02h with sector bits; bit zero set means protected.
// - Reset low is deep power down; wait recovery before the first read.
`timescale 1ns/1ps
`default_nettype none
`include "fbm_regs.vh"
module fbm_host #(
  parameter AW = 19,
  parameter DW = 16
) (
  input  wire          i_clock,         // System clock
  input  wire          i_sys_rst,       // Async reset, active high
  input  wire          i_req,           // Operation request pulse
  input  wire [2:0]    i_op,            // Operation code
  input  wire [AW-1:0] i_addr,          // Address for the operation
  input  wire [DW-1:0] i_wdata,         // Write data
  input  wire          i_dev_reset,     // Request to hold device in reset
  input  wire          i_temp_unprot,   // Request temporary unprotect mode
  input  wire [DW-1:0] i_dq_in,         // Data pins from device
  output reg           o_busy,          // Operation in progress
  output reg           o_done,          // Operation finished pulse
  output reg  [DW-1:0] o_rdata,         // Captured read data
  output reg           o_protected,     // Last protection query result
  output reg  [AW-1:0] o_addr,          // Address pins
  output reg  [DW-1:0] o_dq_out,        // Data pin drive
  output reg           o_dq_oe,         // Data pin drive enable
  output reg           o_chip_sel_n,    // Chip select, active low
  output reg           o_out_gate_n,    // Output gate, active low
  output reg           o_wr_strobe_n,   // Write strobe, active low
  output reg           o_reset_n,       // Device reset, active low
  output reg           o_reset_hv,      // Reset pin raised to elevated voltage
  output reg           o_id_hv,         // Id select line at elevated voltage
  output reg           o_out_gate_hv    // Output gate at elevated voltage
);
  localparam CW = 8;
  // Counts are worked out as integers, then cut to the counter width on purpose
  localparam integer  ACC_I   = `FBM_ACC_CYC;
  localparam integer  REC_I   = `FBM_REC_CYC;
  localparam integer  PULSE_I = `FBM_PULSE_CYC;
  localparam integer  LEAD_I  = `FBM_STB_LEAD;
  localparam integer  CAP_I   = ACC_I + `FBM_SYNC_CYC;
  localparam integer  OFF_I   = LEAD_I + PULSE_I;
  localparam integer  LAST_I  = OFF_I + `FBM_STB_HOLD;
  localparam [CW-1:0] REC_CYC = REC_I[CW-1:0];
  localparam [CW-1:0] CAP_CYC = CAP_I[CW-1:0];
  localparam [CW-1:0] STB_ON  = LEAD_I[CW-1:0];
  localparam [CW-1:0] STB_OFF = OFF_I[CW-1:0];
  localparam [CW-1:0] WR_LAST = LAST_I[CW-1:0];
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RECV = 5'h02;
  localparam [4:0] S_RD   = 5'h04;
  localparam [4:0] S_WR   = 5'h08;
  localparam [4:0] S_END  = 5'h10;

  // ******************************************
  // Input synchroniser, three stages
  // ******************************************
  reg [DW-1:0] dq_s1_r;
  reg [DW-1:0] dq_s2_r;
  reg [DW-1:0] dq_s3_r;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_s1_r <= {DW{1'b0}};
      dq_s2_r <= {DW{1'b0}};
      dq_s3_r <= {DW{1'b0}};
    end else begin
      dq_s1_r <= i_dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  function is_id_op;
    input [2:0] op;
    begin
      is_id_op = (op == `FBM_OP_ID_MFR) || (op == `FBM_OP_ID_DEV) ||
                 (op == `FBM_OP_PROT_VFY);
    end
  endfunction

  // Ops that end in a strobe pulse rather than a data capture
  function is_wr_op;
    input [2:0] op;
    begin
      is_wr_op = (op == `FBM_OP_WRITE) || (op == `FBM_OP_PROTECT) ||
                 (op == `FBM_OP_UNPROT);
    end
  endfunction

  // ******************************************
  // Sequencer
  // ******************************************
  reg [4:0]    state_r;
  reg [CW-1:0] cnt_r;
  reg [2:0]    op_r;
  reg          wake_r;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r       <= S_IDLE;
      cnt_r         <= {CW{1'b0}};
      op_r          <= `FBM_OP_READ;
      wake_r        <= 1'b1;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
      o_rdata       <= {DW{1'b0}};
      o_protected   <= 1'b0;
      o_addr        <= {AW{1'b0}};
      o_dq_out      <= {DW{1'b0}};
      o_dq_oe       <= 1'b0;
      o_chip_sel_n  <= 1'b1;
      o_out_gate_n  <= 1'b1;
      o_wr_strobe_n <= 1'b1;
      o_reset_n     <= 1'b0;
      o_reset_hv    <= 1'b0;
      o_id_hv       <= 1'b0;
      o_out_gate_hv <= 1'b0;
    end else begin
      o_done <= 1'b0;
      o_reset_hv <= i_temp_unprot & ~i_dev_reset;
      case (state_r)
        S_IDLE: begin
          o_chip_sel_n  <= 1'b1;
          o_out_gate_n  <= 1'b1;
          o_wr_strobe_n <= 1'b1;
          o_dq_oe       <= 1'b0;
          o_id_hv       <= 1'b0;
          o_out_gate_hv <= 1'b0;
          if (i_dev_reset) begin
            o_reset_n <= 1'b0;
            wake_r    <= 1'b1;
          end else if (i_req) begin
            o_reset_n <= 1'b1;
            o_busy    <= 1'b1;
            op_r      <= i_op;
            cnt_r     <= {CW{1'b0}};
            o_addr    <= i_addr;
            if (is_id_op(i_op) || i_op == `FBM_OP_PROTECT || i_op == `FBM_OP_UNPROT) begin
              o_id_hv <= 1'b1;
              o_addr[`FBM_OFS_HI:0] <= (i_op == `FBM_OP_ID_MFR) ? `FBM_OFS_MFR :
                                       (i_op == `FBM_OP_ID_DEV) ? `FBM_OFS_DEV :
                                       `FBM_OFS_PROT;
              // unprotect select line high only for unprotect
              o_addr[`FBM_UNPROT_BIT] <= (i_op == `FBM_OP_UNPROT);
            end
            o_dq_out <= i_wdata;
            state_r  <= (o_reset_n == 1'b0 || wake_r) ? S_RECV :
                        (is_wr_op(i_op) ? S_WR : S_RD);
          end else begin
            o_reset_n <= 1'b1;
          end
        end
        S_RECV: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r + 1'b1 >= REC_CYC) begin
            wake_r  <= 1'b0;
            cnt_r   <= {CW{1'b0}};
            state_r <= is_wr_op(op_r) ? S_WR : S_RD;
          end
        end
        S_RD: begin
          o_chip_sel_n <= 1'b0;
          o_out_gate_n <= 1'b0;
          cnt_r <= cnt_r + 1'b1;
          // full access time after each new address
          // Sampling right at the valid instant would race the device, so the
          // capture waits one edge more and for the last two stages to agree
          if (cnt_r >= CAP_CYC && dq_s2_r == dq_s3_r) begin
            o_rdata <= dq_s3_r;
            if (op_r == `FBM_OP_PROT_VFY)
              o_protected <= dq_s3_r[`FBM_PROT_BIT];
            state_r <= S_END;
          end
        end
        S_WR: begin
          // write: select and strobe low, gate high
          o_chip_sel_n  <= 1'b0;
          o_out_gate_n  <= 1'b1;
          o_out_gate_hv <= (op_r != `FBM_OP_WRITE);
          o_dq_oe       <= (op_r == `FBM_OP_WRITE);
          cnt_r <= cnt_r + 1'b1;
          // strobe falls after select, held wide
          if (cnt_r == STB_ON)
            o_wr_strobe_n <= 1'b0;
          // strobe rises first, data held past it
          if (cnt_r == STB_OFF)
            o_wr_strobe_n <= 1'b1;
          if (cnt_r == WR_LAST)
            state_r <= S_END;
        end
        S_END: begin
          o_chip_sel_n  <= 1'b1;
          o_out_gate_n  <= 1'b1;
          o_out_gate_hv <= 1'b0;
          o_dq_oe       <= 1'b0;
          o_id_hv       <= 1'b0;
          o_busy        <= 1'b0;
          o_done        <= 1'b1;
          state_r       <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // fbm_host
`default_nettype wire

// ===== rtl/fbm_regs.vh
`ifndef FBM_REGS_VH
`define FBM_REGS_VH
// Clock period in ps
`define FBM_CLK_PS          10000
// Timing figures in ps as printed
`define FBM_ADDR_ACC_PS     150000
`define FBM_T_RECOVER_PS    50000
`define FBM_T_GLITCH_PS     5000
// Derived cycle counts: least times round up
`define FBM_ACC_CYC   ((`FBM_ADDR_ACC_PS + `FBM_CLK_PS - 1) / `FBM_CLK_PS)
// Sampling lag: three synchroniser stages plus one edge clear of the valid instant
`define FBM_SYNC_CYC  4
// Write pulse framing in cycles: select low to strobe low, strobe high to last write cycle (select rises one cycle later)
`define FBM_STB_LEAD  1
`define FBM_STB_HOLD  1
`define FBM_REC_CYC   ((`FBM_T_RECOVER_PS + `FBM_CLK_PS - 1) / `FBM_CLK_PS)
`define FBM_PULSE_CYC ((`FBM_T_GLITCH_PS + `FBM_CLK_PS - 1) / `FBM_CLK_PS + 1)
// Operation codes on i_op
`define FBM_OP_READ     3'h0
`define FBM_OP_WRITE    3'h1
`define FBM_OP_ID_MFR   3'h2
`define FBM_OP_ID_DEV   3'h3
`define FBM_OP_PROT_VFY 3'h4
`define FBM_OP_PROTECT  3'h5
`define FBM_OP_UNPROT   3'h6
// Identifier address offsets
`define FBM_OFS_MFR     8'h00
`define FBM_OFS_DEV     8'h01
`define FBM_OFS_PROT    8'h02
// Sector field position in the address
`define FBM_SECT_LSB    12
// Bit positions on the address and data pins
`define FBM_OFS_HI      7
`define FBM_UNPROT_BIT  6
`define FBM_PROT_BIT    0
`endif
